// *** hw/cpuxs_pkg.sv ***
// constants and types shared by the instruction semantics datapath
package cpuxs_pkg;

  // ----------------------------------------------------------------
  // operation selector
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CPUXS_OP_NONE,
    CPUXS_OP_DECIMAL_ADJUST,
    CPUXS_OP_DECREMENT,
    CPUXS_OP_INCREMENT,
    CPUXS_OP_XOR,
    CPUXS_OP_REGISTER_SWAP,
    CPUXS_OP_JUMP,
    CPUXS_OP_SUBROUTINE_JUMP,
    CPUXS_OP_BYTE_LOAD,
    CPUXS_OP_WORD_LOAD,
    CPUXS_OP_EA_LOAD,
    CPUXS_OP_SHIFT_LEFT,
    CPUXS_OP_SHIFT_RIGHT,
    CPUXS_OP_MULTIPLY,
    CPUXS_OP_NEGATE,
    CPUXS_OP_NO_OPERATION
  } cpuxs_op_e;

  // ----------------------------------------------------------------
  // condition code bit positions
  // ----------------------------------------------------------------
  localparam int unsigned CPUXS_CC_C = 0;
  localparam int unsigned CPUXS_CC_V = 1;
  localparam int unsigned CPUXS_CC_Z = 2;
  localparam int unsigned CPUXS_CC_N = 3;
  localparam int unsigned CPUXS_CC_H = 5;

  // ----------------------------------------------------------------
  // register swap selector codes
  // ----------------------------------------------------------------
  localparam logic [3:0] CPUXS_SEL_D  = 4'h0;
  localparam logic [3:0] CPUXS_SEL_X  = 4'h1;
  localparam logic [3:0] CPUXS_SEL_Y  = 4'h2;
  localparam logic [3:0] CPUXS_SEL_U  = 4'h3;
  localparam logic [3:0] CPUXS_SEL_S  = 4'h4;
  localparam logic [3:0] CPUXS_SEL_PC = 4'h5;
  localparam logic [3:0] CPUXS_SEL_A  = 4'h8;
  localparam logic [3:0] CPUXS_SEL_B  = 4'h9;
  localparam logic [3:0] CPUXS_SEL_CC = 4'hA;
  localparam logic [3:0] CPUXS_SEL_DP = 4'hB;

  // effective address load targets
  localparam logic [1:0] CPUXS_PTR_X = 2'h0;
  localparam logic [1:0] CPUXS_PTR_Y = 2'h1;
  localparam logic [1:0] CPUXS_PTR_U = 2'h2;
  localparam logic [1:0] CPUXS_PTR_S = 2'h3;

  // word load targets: double accumulator, then the pointers
  localparam logic [2:0] CPUXS_WT_D = 3'h0;
  localparam logic [2:0] CPUXS_WT_X = 3'h1;
  localparam logic [2:0] CPUXS_WT_Y = 3'h2;
  localparam logic [2:0] CPUXS_WT_U = 3'h3;
  localparam logic [2:0] CPUXS_WT_S = 3'h4;

  // ----------------------------------------------------------------
  // data constants
  // ----------------------------------------------------------------
  localparam logic [7:0]  CPUXS_BCD_FIX     = 8'h06;
  localparam logic [3:0]  CPUXS_BCD_NINE    = 4'h9;
  localparam logic [3:0]  CPUXS_BCD_EIGHT   = 4'h8;
  localparam logic [7:0]  CPUXS_DEC_OVF_VAL = 8'h80;
  localparam logic [7:0]  CPUXS_INC_OVF_VAL = 8'h7F;
  localparam logic [7:0]  CPUXS_NEG_OVF_VAL = 8'h80;
  localparam logic [7:0]  CPUXS_BYTE_ONE    = 8'h01;
  localparam logic [15:0] CPUXS_WORD_ONE    = 16'h0001;
  localparam logic [15:0] CPUXS_RST_WORD    = 16'h0000;
  localparam logic [7:0]  CPUXS_RST_BYTE    = 8'h00;
  localparam logic [7:0]  CPUXS_RST_CC      = 8'h50;
  localparam logic [15:0] CPUXS_RST_PC      = 16'h0000;

endpackage : cpuxs_pkg

// *** hw/cpuxs_flags_if.sv ***
// interface carrying a flag update request from the datapath to the flag unit
`timescale 1ns/1ps
interface cpuxs_flags_if;
  logic [7:0] cc_old;   // current condition codes
  logic [7:0] result8;  // byte result for n and z
  logic       upd_nz8;  // take n and z from result8
  logic       clr_n;    // force n low
  logic       set_v;    // load v
  logic       v_val;
  logic       set_c;    // load c
  logic       c_val;
  logic [7:0] cc_new;   // updated condition codes

  modport dp (output cc_old, output result8, output upd_nz8, output clr_n,
              output set_v, output v_val, output set_c, output c_val,
              input cc_new);
  modport fu (input cc_old, input result8, input upd_nz8, input clr_n,
              input set_v, input v_val, input set_c, input c_val,
              output cc_new);
endinterface : cpuxs_flags_if

// *** hw/cpuxs_flag_unit.sv ***
// byte flag update: n and z from one 8-bit result, v and c from the values supplied
`timescale 1ns/1ps
module cpuxs_flag_unit
  import cpuxs_pkg::*;
(
  cpuxs_flags_if.fu f
);

  // ----------------------------------------------------------------
  // flag merge
  // ----------------------------------------------------------------
  logic n_bit;
  logic z_bit;
  assign n_bit = f.clr_n ? 1'b0 : f.result8[7];
  assign z_bit = (f.result8 == CPUXS_RST_BYTE);

  // untouched bits pass through, so h stays unless the caller overrides it
  always_comb begin
    f.cc_new = f.cc_old;
    if (f.upd_nz8) begin
      f.cc_new[CPUXS_CC_N] = n_bit;
      f.cc_new[CPUXS_CC_Z] = z_bit;
    end
    if (f.set_v) begin
      f.cc_new[CPUXS_CC_V] = f.v_val;
    end
    if (f.set_c) begin
      f.cc_new[CPUXS_CC_C] = f.c_val;
    end
  end

endmodule : cpuxs_flag_unit

// *** hw/cpuxs_core.sv ***
// instruction semantics datapath: arithmetic, loads, swaps, jumps and flags
// ------------------------------------------------------------------
// ------------------------------------------------------------------
`timescale 1ns/1ps
module cpuxs_core
  import cpuxs_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                rst_n_i,
  input  wire logic                start_i,
  input  wire cpuxs_pkg::cpuxs_op_e op_i,
  input  wire logic                use_mem_i,
  input  wire logic [7:0]          mem_data_i,
  input  wire logic [15:0]         mem_word_i,
  input  wire logic [15:0]         eff_addr_i,
  input  wire logic [7:0]          post_byte_i,
  input  wire logic [2:0]          target_i,
  input  wire logic                push_ack_i,
  output logic                     busy_o,
  output logic                     done_o,
  output logic                     illegal_o,
  output logic                     mem_wr_o,
  output logic [15:0]              mem_addr_o,
  output logic [7:0]               mem_wdata_o,
  output logic [7:0]               mem_result_o,
  output logic [7:0]               acc_a_o,
  output logic [7:0]               acc_b_o,
  output logic [15:0]              idx_x_o,
  output logic [15:0]              idx_y_o,
  output logic [15:0]              usp_o,
  output logic [15:0]              hsp_o,
  output logic [15:0]              pc_o,
  output logic [7:0]               dp_o,
  output logic [7:0]               cc_o
);

  import cpuxs_pkg::*;

  // ----------------------------------------------------------------
  // architectural registers
  // ----------------------------------------------------------------
  logic [7:0]  a_q, a_d, b_q, b_d, dp_q, dp_d, cc_q, cc_d, memres_q, memres_d;
  logic [15:0] x_q, x_d, y_q, y_d, u_q, u_d, s_q, s_d, pc_q, pc_d;
  logic        done_q, done_d, ill_q, ill_d;

  typedef enum logic [1:0] {CPUXS_ST_IDLE, CPUXS_ST_PUSH_LO, CPUXS_ST_PUSH_HI} cpuxs_state_e;
  cpuxs_state_e state_q, state_d;

  // ----------------------------------------------------------------
  // operand, unary, xor and multiply results
  // ----------------------------------------------------------------
  wire logic [7:0] opnd      = use_mem_i ? mem_data_i : a_q;
  wire logic [7:0] dec_res   = opnd - CPUXS_BYTE_ONE;
  wire logic [7:0] inc_res   = opnd + CPUXS_BYTE_ONE;
  wire logic [7:0] neg_res   = 8'h00 - opnd;
  wire logic [7:0] shl_res   = {opnd[6:0], 1'b0};
  wire logic [7:0] shr_res   = {1'b0, opnd[7:1]};
  wire logic [7:0] xor_res   = a_q ^ mem_data_i;
  wire logic [15:0] mul_res  = a_q * b_q;
  wire logic [15:0] pc_next  = pc_q + CPUXS_WORD_ONE;

  // ----------------------------------------------------------------
  // decimal adjust corrections
  // ----------------------------------------------------------------
  wire logic       lsn_hi  = a_q[3:0] > CPUXS_BCD_NINE;
  wire logic       msn_hi  = a_q[7:4] > CPUXS_BCD_NINE;
  wire logic       msn_gt8 = a_q[7:4] > CPUXS_BCD_EIGHT;
  wire logic       fix_lo  = cc_q[CPUXS_CC_H] | lsn_hi;
  wire logic       fix_hi  = cc_q[CPUXS_CC_C] | msn_hi | (msn_gt8 & lsn_hi);
  wire logic [7:0] daa_fix = {fix_hi ? CPUXS_BCD_FIX[3:0] : 4'h0,
                              fix_lo ? CPUXS_BCD_FIX[3:0] : 4'h0};
  wire logic [8:0] daa_sum = {1'b0, a_q} + {1'b0, daa_fix};

  // ----------------------------------------------------------------
  // register swap selection
  // ----------------------------------------------------------------
  wire logic [3:0] sel_lo = post_byte_i[3:0];
  wire logic [3:0] sel_hi = post_byte_i[7:4];

  function automatic logic sel_ok(input logic [3:0] s);
    sel_ok = (s <= CPUXS_SEL_PC) || ((s >= CPUXS_SEL_A) && (s <= CPUXS_SEL_DP));
  endfunction : sel_ok

  function automatic logic [15:0] sel_read(input logic [3:0] s, input logic [7:0] a,
      input logic [7:0] b, input logic [15:0] x, input logic [15:0] y,
      input logic [15:0] u, input logic [15:0] sp, input logic [15:0] pc,
      input logic [7:0] cc, input logic [7:0] dp);
    case (s)
      CPUXS_SEL_D:  sel_read = {a, b};
      CPUXS_SEL_X:  sel_read = x;
      CPUXS_SEL_Y:  sel_read = y;
      CPUXS_SEL_U:  sel_read = u;
      CPUXS_SEL_S:  sel_read = sp;
      CPUXS_SEL_PC: sel_read = pc;
      CPUXS_SEL_A:  sel_read = {8'h00, a};
      CPUXS_SEL_B:  sel_read = {8'h00, b};
      CPUXS_SEL_CC: sel_read = {8'h00, cc};
      CPUXS_SEL_DP: sel_read = {8'h00, dp};
      default:      sel_read = CPUXS_RST_WORD;
    endcase
  endfunction : sel_read

  wire logic        swap_legal = sel_ok(sel_lo) && sel_ok(sel_hi) &&
                                 (sel_lo[3] == sel_hi[3]);
  wire logic [15:0] val_lo = sel_read(sel_lo, a_q, b_q, x_q, y_q, u_q, s_q, pc_next,
                                      cc_q, dp_q);
  wire logic [15:0] val_hi = sel_read(sel_hi, a_q, b_q, x_q, y_q, u_q, s_q, pc_next,
                                      cc_q, dp_q);

  // ----------------------------------------------------------------
  // byte flag unit
  // ----------------------------------------------------------------
  cpuxs_flags_if fif ();
  cpuxs_flag_unit u_flags (
    .f (fif.fu)
  );

  // each byte operation picks its result and which flags it loads
  always_comb begin
    fif.cc_old  = cc_q;
    fif.result8 = 8'h00;
    fif.upd_nz8 = 1'b0;
    fif.clr_n   = 1'b0;
    fif.set_v   = 1'b0;
    fif.v_val   = 1'b0;
    fif.set_c   = 1'b0;
    fif.c_val   = 1'b0;
    case (op_i)
      CPUXS_OP_DECIMAL_ADJUST: begin
        fif.result8 = daa_sum[7:0];
        fif.upd_nz8 = 1'b1;
        fif.set_c   = 1'b1;
        fif.c_val   = daa_sum[8] | cc_q[CPUXS_CC_C];
      end
      CPUXS_OP_DECREMENT: begin
        fif.result8 = dec_res;
        fif.upd_nz8 = 1'b1;
        fif.set_v   = 1'b1;
        fif.v_val   = (opnd == CPUXS_DEC_OVF_VAL);
      end
      CPUXS_OP_INCREMENT: begin
        fif.result8 = inc_res;
        fif.upd_nz8 = 1'b1;
        fif.set_v   = 1'b1;
        fif.v_val   = (opnd == CPUXS_INC_OVF_VAL);
      end
      CPUXS_OP_XOR, CPUXS_OP_BYTE_LOAD: begin
        fif.result8 = (op_i == CPUXS_OP_XOR) ? xor_res : mem_data_i;
        fif.upd_nz8 = 1'b1;
        fif.set_v   = 1'b1;
      end
      CPUXS_OP_SHIFT_LEFT: begin
        fif.result8 = shl_res;
        fif.upd_nz8 = 1'b1;
        fif.set_v   = 1'b1;
        fif.v_val   = opnd[7] ^ opnd[6];
        fif.set_c   = 1'b1;
        fif.c_val   = opnd[7];
      end
      CPUXS_OP_SHIFT_RIGHT: begin
        fif.result8 = shr_res;
        fif.upd_nz8 = 1'b1;
        fif.clr_n   = 1'b1;
        fif.set_c   = 1'b1;
        fif.c_val   = opnd[0];
      end
      CPUXS_OP_NEGATE: begin
        fif.result8 = neg_res;
        fif.upd_nz8 = 1'b1;
        fif.set_v   = 1'b1;
        fif.v_val   = (opnd == CPUXS_NEG_OVF_VAL);
        fif.set_c   = 1'b1;
        fif.c_val   = (opnd != 8'h00);
      end
      default: begin
        fif.result8 = 8'h00;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // next-state logic; one instruction per start, push takes two acks
  // ----------------------------------------------------------------
  always_comb begin
    a_d = a_q; b_d = b_q; x_d = x_q; y_d = y_q; u_d = u_q; s_d = s_q;
    pc_d = pc_q; dp_d = dp_q; cc_d = cc_q; memres_d = memres_q;
    state_d = state_q; done_d = 1'b0; ill_d = 1'b0;
    case (state_q)
      CPUXS_ST_IDLE: begin
        if (start_i) begin
          done_d = 1'b1;
          pc_d   = pc_next;
          case (op_i)
            CPUXS_OP_DECIMAL_ADJUST, CPUXS_OP_XOR, CPUXS_OP_BYTE_LOAD: begin
              a_d  = fif.result8;
              cc_d = fif.cc_new;
            end
            CPUXS_OP_DECREMENT, CPUXS_OP_INCREMENT, CPUXS_OP_SHIFT_LEFT,
            CPUXS_OP_SHIFT_RIGHT, CPUXS_OP_NEGATE: begin
              cc_d = fif.cc_new;
              if (use_mem_i) begin
                memres_d = fif.result8;     // written back by the memory stage
              end else begin
                a_d = fif.result8;
              end
            end
            CPUXS_OP_MULTIPLY: begin
              {a_d, b_d}         = mul_res;
              cc_d[CPUXS_CC_Z]   = (mul_res == CPUXS_RST_WORD);
              cc_d[CPUXS_CC_C]   = mul_res[7];
            end
            CPUXS_OP_WORD_LOAD: begin
              case (target_i)
                CPUXS_WT_D: {a_d, b_d} = mem_word_i;
                CPUXS_WT_X: x_d = mem_word_i;
                CPUXS_WT_Y: y_d = mem_word_i;
                CPUXS_WT_U: u_d = mem_word_i;
                default:    s_d = mem_word_i;
              endcase
              cc_d[CPUXS_CC_N] = mem_word_i[15];
              cc_d[CPUXS_CC_Z] = (mem_word_i == CPUXS_RST_WORD);
              cc_d[CPUXS_CC_V] = 1'b0;
            end
            CPUXS_OP_EA_LOAD: begin
              case (target_i[1:0])
                CPUXS_PTR_X: x_d = eff_addr_i;
                CPUXS_PTR_Y: y_d = eff_addr_i;
                CPUXS_PTR_U: u_d = eff_addr_i;
                default:     s_d = eff_addr_i;
              endcase
              if (target_i[1:0] == CPUXS_PTR_X || target_i[1:0] == CPUXS_PTR_Y) begin
                cc_d[CPUXS_CC_Z] = (eff_addr_i == CPUXS_RST_WORD);
              end
            end
            CPUXS_OP_REGISTER_SWAP: begin
              if (!swap_legal) begin
                ill_d = 1'b1;
              end else begin
                // low code receives the high register's value and vice versa
                for (int k = 0; k < 2; k++) begin
                  logic [3:0]  dst;
                  logic [15:0] v;
                  dst = (k == 0) ? sel_lo : sel_hi;
                  v   = (k == 0) ? val_hi : val_lo;
                  case (dst)
                    CPUXS_SEL_D:  {a_d, b_d} = v;
                    CPUXS_SEL_X:  x_d  = v;
                    CPUXS_SEL_Y:  y_d  = v;
                    CPUXS_SEL_U:  u_d  = v;
                    CPUXS_SEL_S:  s_d  = v;
                    CPUXS_SEL_PC: pc_d = v;
                    CPUXS_SEL_A:  a_d  = v[7:0];
                    CPUXS_SEL_B:  b_d  = v[7:0];
                    CPUXS_SEL_CC: cc_d = v[7:0];
                    CPUXS_SEL_DP: dp_d = v[7:0];
                    default:      ill_d = 1'b1;
                  endcase
                end
              end
            end
            CPUXS_OP_JUMP: begin
              pc_d = eff_addr_i;
            end
            CPUXS_OP_SUBROUTINE_JUMP: begin
              done_d  = 1'b0;
              s_d     = s_q - CPUXS_WORD_ONE;
              state_d = CPUXS_ST_PUSH_LO;
            end
            CPUXS_OP_NO_OPERATION: begin
              pc_d = pc_next;
            end
            default: begin
              ill_d = 1'b1;
            end
          endcase
        end
      end
      CPUXS_ST_PUSH_LO: begin
        if (push_ack_i) begin
          s_d     = s_q - CPUXS_WORD_ONE;
          state_d = CPUXS_ST_PUSH_HI;
        end
      end
      CPUXS_ST_PUSH_HI: begin
        if (push_ack_i) begin
          pc_d    = eff_addr_i;
          done_d  = 1'b1;
          state_d = CPUXS_ST_IDLE;
        end
      end
      default: begin
        state_d = CPUXS_ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      a_q <= CPUXS_RST_BYTE; b_q <= CPUXS_RST_BYTE; dp_q <= CPUXS_RST_BYTE;
      cc_q <= CPUXS_RST_CC; memres_q <= CPUXS_RST_BYTE;
      x_q <= CPUXS_RST_WORD; y_q <= CPUXS_RST_WORD; u_q <= CPUXS_RST_WORD;
      s_q <= CPUXS_RST_WORD; pc_q <= CPUXS_RST_PC;
      done_q <= 1'b0; ill_q <= 1'b0; state_q <= CPUXS_ST_IDLE;
    end else begin
      a_q <= a_d; b_q <= b_d; dp_q <= dp_d; cc_q <= cc_d; memres_q <= memres_d;
      x_q <= x_d; y_q <= y_d; u_q <= u_d; s_q <= s_d; pc_q <= pc_d;
      done_q <= done_d; ill_q <= ill_d; state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs; push write is held until the memory side acknowledges
  // ----------------------------------------------------------------
  assign busy_o       = (state_q != CPUXS_ST_IDLE);
  assign done_o       = done_q;
  assign illegal_o    = ill_q;
  assign mem_wr_o     = busy_o;
  assign mem_addr_o   = s_q;
  assign mem_wdata_o  = (state_q == CPUXS_ST_PUSH_LO) ? pc_q[7:0] : pc_q[15:8];
  assign mem_result_o = memres_q;
  assign acc_a_o      = a_q;
  assign acc_b_o      = b_q;
  assign idx_x_o      = x_q;
  assign idx_y_o      = y_q;
  assign usp_o        = u_q;
  assign hsp_o        = s_q;
  assign pc_o         = pc_q;
  assign dp_o         = dp_q;
  assign cc_o         = cc_q;

endmodule : cpuxs_core

// *** tb/cpuxs_core_properties.sv ***
// concurrent property checker for the instruction semantics datapath
`timescale 1ns/1ps
module cpuxs_core_properties
  import cpuxs_pkg::*;
(
  input wire logic                 clk_i,
  input wire logic                 rst_n_i,
  input wire logic                 start_i,
  input wire logic                 busy_o,
  input wire logic                 mem_wr_o,
  input wire logic                 use_mem_i,
  input wire cpuxs_pkg::cpuxs_op_e op_i,
  input wire logic [7:0]           mem_data_i,
  input wire logic [7:0]           mem_wdata_o,
  input wire logic [7:0]           mem_result_o,
  input wire logic [7:0]           acc_a_o,
  input wire logic [7:0]           acc_b_o,
  input wire logic [7:0]           cc_o,
  input wire logic [15:0]          eff_addr_i,
  input wire logic [15:0]          mem_addr_o,
  input wire logic [15:0]          hsp_o,
  input wire logic [15:0]          pc_o
);
  // ----------------------------------------------------------------
  // accepted request and first push step
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_go(cpuxs_op_e o);
    start_i && !busy_o && op_i == o;
  endsequence
  // low byte of the advanced pc goes first, one below the old stack pointer
  sequence s_push_lo;
    busy_o && mem_wr_o && mem_addr_o == $past(hsp_o) - 16'h0001
    && mem_wdata_o == 8'($past(pc_o) + 16'h0001);
  endsequence

  a_inc_overflow: assert property (
    s_go(CPUXS_OP_INCREMENT) ##0 (use_mem_i && mem_data_i == 8'h7F)
    |=> cc_o[1] && mem_result_o == 8'h80) else $error("increment overflow wrong");
  a_xor_result: assert property (
    s_go(CPUXS_OP_XOR) |=> !cc_o[1] && acc_a_o == ($past(acc_a_o) ^ $past(mem_data_i)))
    else $error("xor result wrong");
  a_shr_flags: assert property (
    s_go(CPUXS_OP_SHIFT_RIGHT) |=> !cc_o[3] && $stable(cc_o[1])) else $error("shift right flags");
  a_neg_zero: assert property (
    s_go(CPUXS_OP_NEGATE) ##0 (use_mem_i && mem_data_i == 8'h00)
    |=> !cc_o[0] && cc_o[2] && mem_result_o == 8'h00) else $error("negate of zero wrong");
  a_jump_target: assert property (
    s_go(CPUXS_OP_JUMP) |=> pc_o == $past(eff_addr_i) && $stable(cc_o)) else $error("jump wrong");
  a_nop_pc_only: assert property (
    s_go(CPUXS_OP_NO_OPERATION) |=> pc_o == $past(pc_o) + 16'h0001 && $stable(cc_o)
    && $stable(acc_a_o)) else $error("no operation changed state");
  a_call_push_order: assert property (
    s_go(CPUXS_OP_SUBROUTINE_JUMP) |=> s_push_lo) else $error("first push wrong");
  a_mul_product: assert property (
    s_go(CPUXS_OP_MULTIPLY) |=> {acc_a_o, acc_b_o} == $past(acc_a_o) * $past(acc_b_o)
    && cc_o[0] == acc_b_o[7]) else $error("multiply wrong");
endmodule : cpuxs_core_properties

bind cpuxs_core cpuxs_core_properties u_props (
  .clk_i        (clk_i),
  .rst_n_i      (rst_n_i),
  .start_i      (start_i),
  .busy_o       (busy_o),
  .mem_wr_o     (mem_wr_o),
  .use_mem_i    (use_mem_i),
  .op_i         (op_i),
  .mem_data_i   (mem_data_i),
  .mem_wdata_o  (mem_wdata_o),
  .mem_result_o (mem_result_o),
  .acc_a_o      (acc_a_o),
  .acc_b_o      (acc_b_o),
  .cc_o         (cc_o),
  .eff_addr_i   (eff_addr_i),
  .mem_addr_o   (mem_addr_o),
  .hsp_o        (hsp_o),
  .pc_o         (pc_o)
);

// *** tb/cpuxs_core_tb.sv ***
// self-checking bench for the instruction semantics datapath
`timescale 1ns/1ps
module cpuxs_core_tb;
  import cpuxs_pkg::*;
  logic        clk_i = 1'b0, rst_n_i = 1'b0, start_i = 1'b0, use_mem_i = 1'b1, push_ack_i = 1'b0;
  cpuxs_op_e   op_i = CPUXS_OP_NONE;
  logic [7:0]  mem_data_i = 8'h00, post_byte_i = 8'h00;
  logic [15:0] mem_word_i = 16'h0000, eff_addr_i = 16'h0000;
  logic [2:0]  target_i = 3'h0;
  logic        busy_o, done_o, illegal_o, mem_wr_o;
  logic [7:0]  mem_wdata_o, mem_result_o, acc_a_o, acc_b_o, dp_o, cc_o;
  logic [15:0] mem_addr_o, idx_x_o, idx_y_o, usp_o, hsp_o, pc_o;
  int          mismatches = 0, check_count = 0;

  cpuxs_core uut (
    .clk_i        (clk_i),
    .rst_n_i      (rst_n_i),
    .start_i      (start_i),
    .op_i         (op_i),
    .use_mem_i    (use_mem_i),
    .mem_data_i   (mem_data_i),
    .mem_word_i   (mem_word_i),
    .eff_addr_i   (eff_addr_i),
    .post_byte_i  (post_byte_i),
    .target_i     (target_i),
    .push_ack_i   (push_ack_i),
    .busy_o       (busy_o),
    .done_o       (done_o),
    .illegal_o    (illegal_o),
    .mem_wr_o     (mem_wr_o),
    .mem_addr_o   (mem_addr_o),
    .mem_wdata_o  (mem_wdata_o),
    .mem_result_o (mem_result_o),
    .acc_a_o      (acc_a_o),
    .acc_b_o      (acc_b_o),
    .idx_x_o      (idx_x_o),
    .idx_y_o      (idx_y_o),
    .usp_o        (usp_o),
    .hsp_o        (hsp_o),
    .pc_o         (pc_o),
    .dp_o         (dp_o),
    .cc_o         (cc_o)
  );
  always #4 clk_i = ~clk_i;
  // watchdog so a stuck run still reaches the verdict
  initial begin
    #100000;
    mismatches++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one op: raised at an edge, taken at the next, results settle 1 ns later
  task run(input cpuxs_op_e o, input logic [15:0] w = 16'h0, input logic [7:0] pb = 8'h0,
           input logic um = 1'b1);
    @(posedge clk_i);
    start_i <= 1'b1;
    op_i <= o;
    mem_data_i <= w[7:0];
    mem_word_i <= w;
    eff_addr_i <= w;
    post_byte_i <= pb;
    target_i <= pb[2:0];
    use_mem_i <= um;
    @(posedge clk_i);
    start_i <= 1'b0;
    #1;
  endtask : run
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------
  // scenarios; flags carry over, so the order matters
  // ----------------------------------------------------------------
  task t_bcd;
    run(CPUXS_OP_BYTE_LOAD, 16'h009A);
    run(CPUXS_OP_DECIMAL_ADJUST);
    chk(acc_a_o, 16'h0000);
    chk(cc_o, 16'h0055);
    run(CPUXS_OP_DECIMAL_ADJUST);
    chk({acc_a_o, cc_o}, 16'h6051);
    $display("bcd done");
  endtask : t_bcd
  task t_count;
    run(CPUXS_OP_INCREMENT, 16'h007F);
    chk({mem_result_o, cc_o}, 16'h805B);
    run(CPUXS_OP_DECREMENT, 16'h0080);
    chk({mem_result_o, cc_o}, 16'h7F53);
    run(CPUXS_OP_INCREMENT, 16'h0000, 8'h00, 1'b0);
    chk({acc_a_o, cc_o}, 16'h6151);
    run(CPUXS_OP_XOR, 16'h0061);
    chk({acc_a_o, cc_o}, 16'h0055);
    $display("count done");
  endtask : t_count
  task t_load_swap;
    run(CPUXS_OP_BYTE_LOAD, 16'h0080);
    chk({acc_a_o, cc_o}, 16'h8059);
    run(CPUXS_OP_WORD_LOAD, 16'h8001, 8'h00);
    chk({acc_a_o, acc_b_o}, 16'h8001);
    run(CPUXS_OP_WORD_LOAD, 16'h0000, 8'h01);
    chk(cc_o, 16'h0055);
    run(CPUXS_OP_REGISTER_SWAP, 16'h0, 8'h98);
    chk({acc_a_o, acc_b_o}, 16'h0180);
    run(CPUXS_OP_REGISTER_SWAP, 16'h0, 8'h08);
    chk({illegal_o, acc_a_o}, 16'h0101);
    run(CPUXS_OP_REGISTER_SWAP, 16'h0, 8'hA8);
    chk({acc_a_o, cc_o}, 16'h5501);
    $display("load and swap done");
  endtask : t_load_swap
  task t_ea_shift;
    run(CPUXS_OP_EA_LOAD, 16'h0000, 8'h00);
    chk(cc_o, 16'h0005);
    run(CPUXS_OP_EA_LOAD, 16'h0300, 8'h03);
    chk({hsp_o[11:0], cc_o[3:0]}, 16'h3005);
    run(CPUXS_OP_SHIFT_LEFT, 16'h0040);
    chk({mem_result_o, cc_o}, 16'h800A);
    run(CPUXS_OP_SHIFT_RIGHT, 16'h0001);
    chk({mem_result_o, cc_o}, 16'h0007);
    $display("ea and shift done");
  endtask : t_ea_shift
  task t_arith;
    run(CPUXS_OP_WORD_LOAD, 16'h0C0A, 8'h00);
    run(CPUXS_OP_MULTIPLY);
    chk({acc_b_o, cc_o}, 16'h7800);
    run(CPUXS_OP_NEGATE, 16'h0080);
    chk({mem_result_o, cc_o}, 16'h800B);
    run(CPUXS_OP_NEGATE, 16'h0000);
    chk({mem_result_o, cc_o}, 16'h0004);
    $display("arith done");
  endtask : t_arith
  task t_flow;
    run(CPUXS_OP_JUMP, 16'h1000);
    chk(pc_o, 16'h1000);
    run(CPUXS_OP_NO_OPERATION);
    chk({pc_o[7:0], cc_o}, 16'h0104);
    run(CPUXS_OP_SUBROUTINE_JUMP, 16'h2000);
    chk({mem_addr_o[7:0], mem_wdata_o}, 16'hFF02);
    chk({busy_o, mem_wr_o}, 16'h0003);
    @(posedge clk_i) push_ack_i <= 1'b1;
    @(posedge clk_i);
    #1 chk({mem_addr_o[7:0], mem_wdata_o}, 16'hFE10);
    for (int i = 0; i < 4 && done_o !== 1'b1; i++) begin
      @(posedge clk_i) push_ack_i <= 1'b0;
      #1;
    end
    if (done_o !== 1'b1) begin
      mismatches++;
      finish_test();
    end
    chk(pc_o ^ hsp_o, 16'h2000 ^ 16'h02FE);
    chk(busy_o, 16'h0000);
    $display("flow done");
  endtask : t_flow
  // pointer, page register and undefined-code paths the earlier tasks miss
  task t_regs;
    run(CPUXS_OP_WORD_LOAD, 16'h1234, 8'h03);
    chk(usp_o, 16'h1234);
    chk({busy_o, done_o, illegal_o}, 16'h0002);
    run(CPUXS_OP_REGISTER_SWAP, 16'h0, 8'h23);
    chk(idx_y_o, 16'h1234);
    chk({usp_o[7:0], cc_o}, 16'h0000);
    run(CPUXS_OP_EA_LOAD, 16'h8000, 8'h01);
    chk(idx_y_o, 16'h8000);
    run(CPUXS_OP_EA_LOAD, 16'h0000, 8'h02);
    chk(cc_o, 16'h0000);
    run(CPUXS_OP_BYTE_LOAD, 16'h00C3);
    run(CPUXS_OP_REGISTER_SWAP, 16'h0, 8'hB8);
    chk({dp_o, acc_a_o}, 16'hC300);
    run(CPUXS_OP_REGISTER_SWAP, 16'h0, 8'hC8);
    chk({illegal_o, dp_o}, 16'h01C3);
    run(CPUXS_OP_WORD_LOAD, 16'h00FF, 8'h01);
    chk(idx_x_o, 16'h00FF);
    $display("register paths done");
  endtask : t_regs

  initial begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_bcd();
    t_count();
    t_load_swap();
    t_ea_shift();
    t_arith();
    t_flow();
    t_regs();
    finish_test();
  end
endmodule : cpuxs_core_tb
